// *** sadc_pkg.sv ***
package sadc_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses, one 32-bit word each)
  // ---------------------------------------------------------------
  localparam logic [3:0] OFF_SCR = 4'h0;
  localparam logic [3:0] OFF_RESH = 4'h4;
  localparam logic [3:0] OFF_RESL = 4'h8;
  localparam logic [3:0] OFF_CLK = 4'hC;

  // ---------------------------------------------------------------
  // status and control register fields
  // ---------------------------------------------------------------
  localparam int SCR_DONE_BIT = 7;
  localparam int SCR_IEN_BIT = 6;
  localparam int SCR_CONT_BIT = 5;
  localparam int CH_W = 5;
  localparam logic [4:0] CH_OFF = 5'h1F;
  localparam logic [4:0] CH_REFH = 5'h1D;
  localparam logic [4:0] CH_REFL = 5'h1E;
  localparam logic [4:0] CH_PINS = 5'h18;
  localparam logic [7:0] SCR_RST = 8'h1F;

  // ---------------------------------------------------------------
  // converter clock register fields
  // ---------------------------------------------------------------
  localparam int CLK_DIV_LSB = 5;
  localparam int CLK_DIV_W = 3;
  localparam int CLK_SRC_BIT = 4;
  localparam int CLK_FMT_LSB = 2;
  localparam logic [7:0] CLK_RST = 8'h00;

  // ---------------------------------------------------------------
  // conversion resolution, first trial code and timing in converter clock ticks
  // ---------------------------------------------------------------
  localparam int RES_BITS = 10;
  localparam logic [4:0] CONV_LAST = 5'h10;
  localparam logic [4:0] FIRST_RESOLVE = 5'h07;
  localparam logic [9:0] SAR_TOP = 10'h200;

  typedef enum logic [1:0] {
    FMT_LEFT,
    FMT_RIGHT,
    FMT_LSIGN,
    FMT_TRUNC
  } sadc_fmt_e;

endpackage

// *** sadc_sync.sv ***
`timescale 1ns/1ns
module sadc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // asynchronous levels in, filtered levels out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_q;

  // a bit moves only once the second and third stages agree
  always_comb begin
    for (int i = 0; i < W; i++) begin
      next_q[i] = (s2[i] == s3[i]) ? s3[i] : q[i];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q <= '0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q <= next_q;
    end
  end

endmodule

// *** sadc_clkdiv.sv ***
`timescale 1ns/1ns
module sadc_clkdiv (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // source and divider selection
  input wire logic src_sel,
  input wire logic [sadc_pkg::CLK_DIV_W-1:0] div,
  input wire logic alt_tick,
  // one pulse per converter clock period
  output logic tick
);

  logic [15:0] count;
  logic [15:0] next_count;
  logic next_tick;
  logic src_pulse;
  logic [15:0] limit;

  always_comb begin
    src_pulse = src_sel ? alt_tick : 1'b1;
    limit = (16'h0001 << div) - 16'h0001;
    next_count = count;
    next_tick = 1'b0;
    if (src_pulse) begin
      if (count >= limit) begin
        next_count = 16'h0000;
        next_tick = 1'b1;
      end else begin
        next_count = count + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      count <= 16'h0000;
      tick <= 1'b0;
    end else begin
      count <= next_count;
      tick <= next_tick;
    end
  end

endmodule

// *** sadc_ctrl.sv ***
// The address map and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ns
module sadc_ctrl (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // port pins shared with the converter
  input wire logic [23:0] pin_in,
  input wire logic [23:0] port_data,
  input wire logic [23:0] port_dir,
  output logic [23:0] pin_out,
  output logic [23:0] pin_oe,
  output logic [23:0] port_rd_data,
  // analog front end
  input wire logic cmp_in,
  input wire logic alt_tick,
  output logic [9:0] dac_code,
  output logic [4:0] amux_sel,
  output logic adc_power_on,
  // low power and interrupt
  input wire logic cpu_stop,
  output logic irq
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [23:0] pin_mask(input logic [4:0] ch);
    return (ch < sadc_pkg::CH_PINS) ? (24'h000001 << ch) : 24'h000000;
  endfunction

  function automatic logic [3:0] bit_index(input logic [4:0] c);
    logic [4:0] d;
    d = sadc_pkg::CONV_LAST - c;
    return d[3:0];
  endfunction

  // keep or drop the trial bit, then try the next lower one
  function automatic logic [9:0] resolve(input logic [9:0] s, input logic [3:0] i, input logic c);
    logic [9:0] r;
    r = s;
    if (!c) begin
      r[i] = 1'b0;
    end
    if (i != 4'h0) begin
      r[i - 4'h1] = 1'b1;
    end
    return r;
  endfunction

  function automatic logic [7:0] fmt_high(input logic [9:0] v, input sadc_pkg::sadc_fmt_e f);
    logic [7:0] h;
    h = 8'h00;
    unique case (f)
      sadc_pkg::FMT_LEFT: h = v[9:2];
      sadc_pkg::FMT_RIGHT: h = {6'h00, v[9:8]};
      sadc_pkg::FMT_LSIGN: h = {~v[9], v[8:2]};
      sadc_pkg::FMT_TRUNC: h = 8'h00;
    endcase
    return h;
  endfunction

  function automatic logic [7:0] fmt_low(input logic [9:0] v, input sadc_pkg::sadc_fmt_e f);
    logic [7:0] l;
    l = 8'h00;
    unique case (f)
      sadc_pkg::FMT_LEFT, sadc_pkg::FMT_LSIGN: l = {v[1:0], 6'h00};
      sadc_pkg::FMT_RIGHT: l = v[7:0];
      sadc_pkg::FMT_TRUNC: l = v[9:2];
    endcase
    return l;
  endfunction

  // ---------------------------------------------------------------
  // synchronisers and converter clock
  // ---------------------------------------------------------------
  logic [24:0] sync_q;
  logic cmp, tick, clk_src;
  logic [sadc_pkg::CLK_DIV_W-1:0] clk_div;
  sadc_pkg::sadc_fmt_e fmt;

  sadc_sync #(.W(25)) u_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .d({cmp_in, pin_in}),
    .q(sync_q)
  );

  assign cmp = sync_q[24];

  sadc_clkdiv u_div (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .src_sel(clk_src),
    .div(clk_div),
    .alt_tick(alt_tick),
    .tick(tick)
  );

  // ---------------------------------------------------------------
  // bus slave: one wait cycle, effects at the completing edge
  // ---------------------------------------------------------------
  logic next_waitreq, wr_done, rd_done, wr_scr, wr_clk, rd_hi, rd_lo, rd_data;
  logic [31:0] next_rdata;
  logic scr_ien, scr_cont, done_flag, locked;
  logic [4:0] scr_ch;
  logic [9:0] raw;

  always_comb begin
    wr_done = avs_write && !avs_waitrequest;
    rd_done = avs_read && !avs_waitrequest;
    wr_scr = wr_done && avs_address == sadc_pkg::OFF_SCR && avs_byteenable[0];
    wr_clk = wr_done && avs_address == sadc_pkg::OFF_CLK && avs_byteenable[0];
    rd_hi = rd_done && avs_address == sadc_pkg::OFF_RESH;
    rd_lo = rd_done && avs_address == sadc_pkg::OFF_RESL;
    rd_data = rd_hi || rd_lo;
    next_waitreq = !((avs_read || avs_write) && avs_waitrequest);
    next_rdata = 32'h00000000;
    if (avs_read && avs_waitrequest) begin
      unique case (avs_address)
        sadc_pkg::OFF_SCR: next_rdata = {24'h000000, done_flag, scr_ien, scr_cont, scr_ch};
        sadc_pkg::OFF_RESH: next_rdata = {24'h000000, fmt_high(raw, fmt)};
        sadc_pkg::OFF_RESL: next_rdata = {24'h000000, fmt_low(raw, fmt)};
        sadc_pkg::OFF_CLK: next_rdata = {24'h000000, clk_div, clk_src, fmt, 2'h0};
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      avs_waitrequest <= next_waitreq;
      avs_readdata <= next_rdata;
    end
  end

  // ---------------------------------------------------------------
  // control registers and conversion sequencer
  // ---------------------------------------------------------------
  typedef enum logic {ST_IDLE, ST_CONV} sadc_state_e;
  sadc_state_e state;
  sadc_state_e next_state;
  logic busy, resume, done, start, irq_q, powered;
  logic [4:0] cnt, next_cnt, next_ch;
  logic [9:0] sar, next_sar, next_raw;
  logic next_ien, next_cont, next_src, next_resume, next_locked, next_done_flag, next_irq;
  logic [sadc_pkg::CLK_DIV_W-1:0] next_div;
  sadc_pkg::sadc_fmt_e next_fmt;

  assign busy = state == ST_CONV;
  assign done = busy && tick && cnt == sadc_pkg::CONV_LAST;

  always_comb begin
    next_ien = scr_ien;
    next_cont = scr_cont;
    next_ch = scr_ch;
    next_div = clk_div;
    next_src = clk_src;
    next_fmt = fmt;
    if (wr_scr) begin
      // the done bit is read-only, its write position is ignored
      next_ien = avs_writedata[sadc_pkg::SCR_IEN_BIT];
      next_cont = avs_writedata[sadc_pkg::SCR_CONT_BIT];
      next_ch = avs_writedata[sadc_pkg::CH_W-1:0];
    end
    if (wr_clk) begin
      next_div = avs_writedata[sadc_pkg::CLK_DIV_LSB +: sadc_pkg::CLK_DIV_W];
      next_src = avs_writedata[sadc_pkg::CLK_SRC_BIT];
      next_fmt = sadc_pkg::sadc_fmt_e'(avs_writedata[sadc_pkg::CLK_FMT_LSB +: 2]);
    end
    powered = next_ch != sadc_pkg::CH_OFF;
    // a control write restarts, so a result in flight is replaced
    start = (wr_scr || (done && scr_cont) || (resume && !busy)) && powered;
    next_state = state;
    next_cnt = cnt;
    next_sar = sar;
    next_resume = resume;
    if (cpu_stop) begin
      // abort now, pick up again once the stop request drops
      next_state = ST_IDLE;
      next_resume = resume || busy || wr_scr || scr_cont;
    end else if (start) begin
      next_state = ST_CONV;
      next_cnt = 5'h00;
      next_sar = sadc_pkg::SAR_TOP;
      next_resume = 1'b0;
    end else if (!powered) begin
      next_state = ST_IDLE;
      next_resume = 1'b0;
    end else if (busy && tick) begin
      // first tick only aligns to the converter clock, hence 16 to 17
      next_cnt = cnt + 5'h01;
      if (cnt >= sadc_pkg::FIRST_RESOLVE) begin
        next_sar = resolve(sar, bit_index(cnt), cmp);
      end
      if (done) begin
        next_state = ST_IDLE;
      end
    end
    next_raw = raw;
    if (done && !locked) begin
      next_raw = resolve(sar, 4'h0, cmp);
    end
    next_locked = (locked && !rd_lo) || (rd_hi && fmt != sadc_pkg::FMT_TRUNC);
    if (next_fmt == sadc_pkg::FMT_TRUNC) begin
      next_locked = 1'b0;
    end
    next_done_flag = !next_ien && ((done && !scr_ien) || (done_flag && !rd_data));
    // a wait-state cpu is woken by this same level
    next_irq = (done && scr_ien) || (irq_q && !rd_data && !wr_scr);
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      scr_ien <= sadc_pkg::SCR_RST[sadc_pkg::SCR_IEN_BIT];
      scr_cont <= sadc_pkg::SCR_RST[sadc_pkg::SCR_CONT_BIT];
      scr_ch <= sadc_pkg::SCR_RST[sadc_pkg::CH_W-1:0];
      clk_div <= sadc_pkg::CLK_RST[sadc_pkg::CLK_DIV_LSB +: sadc_pkg::CLK_DIV_W];
      clk_src <= sadc_pkg::CLK_RST[sadc_pkg::CLK_SRC_BIT];
      fmt <= sadc_pkg::FMT_LEFT;
      state <= ST_IDLE;
      cnt <= 5'h00;
      sar <= 10'h000;
      resume <= 1'b0;
      raw <= 10'h000;
      locked <= 1'b0;
      done_flag <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      scr_ien <= next_ien;
      scr_cont <= next_cont;
      scr_ch <= next_ch;
      clk_div <= next_div;
      clk_src <= next_src;
      fmt <= next_fmt;
      state <= next_state;
      cnt <= next_cnt;
      sar <= next_sar;
      resume <= next_resume;
      raw <= next_raw;
      locked <= next_locked;
      done_flag <= next_done_flag;
      irq_q <= next_irq;
    end
  end

  assign irq = irq_q;
  assign dac_code = sar;
  assign amux_sel = scr_ch;

  // ---------------------------------------------------------------
  // port override for the selected pin
  // ---------------------------------------------------------------
  logic [23:0] sel_mask;
  logic [23:0] next_pin_oe;
  logic [23:0] next_port_rd;

  always_comb begin
    sel_mask = pin_mask(scr_ch);
    next_pin_oe = port_dir & ~sel_mask;
    next_port_rd = sync_q[23:0] & ~sel_mask;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pin_out <= 24'h000000;
      pin_oe <= 24'h000000;
      port_rd_data <= 24'h000000;
      adc_power_on <= 1'b0;
    end else begin
      pin_out <= port_data;
      pin_oe <= next_pin_oe;
      port_rd_data <= next_port_rd;
      adc_power_on <= scr_ch != sadc_pkg::CH_OFF;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [4:0] tick_hist;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tick_hist <= 5'h00;
    end else if (start && !cpu_stop) begin
      tick_hist <= 5'h00;
    end else if (busy && tick) begin
      tick_hist <= tick_hist + 5'h01;
    end
  end

  AST_START: assert property (@(posedge clk_sys) disable iff (!nrst)
    (wr_scr && avs_writedata[4:0] != sadc_pkg::CH_OFF && !cpu_stop) |=> (busy && cnt == 5'h00))
    else $error("control write did not start a conversion");
  AST_TICKS: assert property (@(posedge clk_sys) disable iff (!nrst)
    done |-> tick_hist == sadc_pkg::CONV_LAST)
    else $error("conversion length is not 17 converter ticks");
  AST_DONE_FLAG: assert property (@(posedge clk_sys) disable iff (!nrst)
    (done && !scr_ien && !wr_scr) |=> done_flag ##1 (done_flag || $past(rd_data) || $past(wr_scr)))
    else $error("done flag missing after conversion");
  AST_NO_FLAG_IRQ: assert property (@(posedge clk_sys) disable iff (!nrst)
    scr_ien |-> !done_flag)
    else $error("done flag set while interrupts enabled");
  AST_IRQ: assert property (@(posedge clk_sys) disable iff (!nrst)
    (done && scr_ien) |=> irq)
    else $error("no interrupt after conversion");
  AST_IRQ_CLR: assert property (@(posedge clk_sys) disable iff (!nrst)
    ((rd_data || wr_scr) && !done) |=> !irq)
    else $error("interrupt not cleared by read or control write");
  AST_SINGLE: assert property (@(posedge clk_sys) disable iff (!nrst)
    (done && !scr_cont && !wr_scr && !cpu_stop) |=> !busy ##1 (!busy || $past(start)))
    else $error("single mode did not go idle");
  AST_CONT: assert property (@(posedge clk_sys) disable iff (!nrst)
    (done && scr_cont && !wr_scr && !cpu_stop) |=> (busy && cnt == 5'h00))
    else $error("continuous mode did not restart");
  AST_LOCK: assert property (@(posedge clk_sys) disable iff (!nrst)
    locked |=> $stable(raw))
    else $error("result stored while interlocked");
  AST_STOP: assert property (@(posedge clk_sys) disable iff (!nrst)
    cpu_stop |=> !busy)
    else $error("conversion survived stop");
  AST_PIN_OE: assert property (@(posedge clk_sys) disable iff (!nrst)
    (scr_ch < sadc_pkg::CH_PINS) |=> !pin_oe[$past(scr_ch)])
    else $error("selected pin still driven by port");
  AST_PIN_RD: assert property (@(posedge clk_sys) disable iff (!nrst)
    (scr_ch < sadc_pkg::CH_PINS) |=> !port_rd_data[$past(scr_ch)])
    else $error("selected pin reads nonzero");

endmodule

// *** test_sadc_ctrl.sv ***
`timescale 1ns/1ns
module test_sadc_ctrl;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic clk_sys, nrst, avs_read, avs_write, avs_waitrequest;
  logic cmp_in, alt_tick, adc_power_on, cpu_stop, irq;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [23:0] pin_in, port_data, port_dir, pin_out, pin_oe, port_rd_data;
  logic [9:0] dac_code, vin;
  logic [4:0] amux_sel, c;
  logic [7:0] fh [4] = '{8'hAD, 8'h02, 8'h2D, 8'h00};
  logic [7:0] fl [4] = '{8'h80, 8'hB6, 8'h80, 8'hAD};
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  int t0 = 0;

  sadc_ctrl u_sadc_ctrl (
    .clk_sys(clk_sys), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pin_in(pin_in), .port_data(port_data), .port_dir(port_dir),
    .pin_out(pin_out), .pin_oe(pin_oe), .port_rd_data(port_rd_data),
    .cmp_in(cmp_in), .alt_tick(alt_tick), .dac_code(dac_code),
    .amux_sel(amux_sel), .adc_power_on(adc_power_on),
    .cpu_stop(cpu_stop), .irq(irq)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ---------------------------------------------------------------
  // analog side: references give full and zero scale
  // ---------------------------------------------------------------
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    alt_tick <= (cyc % 8 == 0);
    cmp_in <= ((amux_sel == sadc_pkg::CH_REFH) ? 10'h3FF :
               (amux_sel == sadc_pkg::CH_REFL) ? 10'h000 : vin) >= dac_code;
  end

  // ---------------------------------------------------------------
  // compare and report
  // ---------------------------------------------------------------
  task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_pins(input string nm, input logic [23:0] e, input logic [23:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic tmo(input string nm);
    n_fail++;
    $display("CHECK FAILED %s expected completion seen timeout", nm);
    wrap_up();
  endtask

  // ---------------------------------------------------------------
  // bus master: entered just after a rising edge
  // ---------------------------------------------------------------
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    int i;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= ~wr;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 20) tmo("bus");
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // one idle edge so a strobe is never dropped and raised in one step
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input string nm, input logic [3:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk_reg(nm, {24'h0, e}, rd);
  endtask

  // polls the done flag; tick period is 8 clocks throughout
  task automatic wait_done(input logic tm);
    int i;
    for (i = 0; i < 200; i++) begin
      bus(1'b0, sadc_pkg::OFF_SCR, 8'h00);
      if (rd[sadc_pkg::SCR_DONE_BIT] === 1'b1) break;
    end
    if (i == 200) tmo("done flag");
    if (tm) chk_bit("conversion time", 1'b1, (cyc - t0 >= 120) && (cyc - t0 <= 152));
  endtask

  task automatic conv(input logic [7:0] scr);
    wr(sadc_pkg::OFF_SCR, scr);
    t0 = cyc;
    wait_done(1'b1);
  endtask

  task automatic wait_irq();
    int i;
    for (i = 0; i < 200; i++) begin
      @(posedge clk_sys);
      if (irq === 1'b1) break;
    end
    if (i == 200) tmo("irq");
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h1;
    pin_in = 24'h0;
    port_data = 24'h0;
    port_dir = 24'h0;
    cpu_stop = 1'b0;
    cmp_in = 1'b0;
    alt_tick = 1'b0;
    vin = 10'h000;
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    chk_bit("power after reset", 1'b0, adc_power_on);
    rdc("control reset", sadc_pkg::OFF_SCR, sadc_pkg::SCR_RST);
    rdc("clock reset", sadc_pkg::OFF_CLK, sadc_pkg::CLK_RST);
    rdc("unmapped", 4'h2, 8'h00);
    wr(sadc_pkg::OFF_CLK, 8'h60);
    rdc("clock reg", sadc_pkg::OFF_CLK, 8'h60);
    // ignored write leaves the converter off
    avs_byteenable <= 4'h0;
    wr(sadc_pkg::OFF_SCR, 8'h05);
    avs_byteenable <= 4'h1;
    rdc("masked write", sadc_pkg::OFF_SCR, sadc_pkg::SCR_RST);
    conv(8'h1D);
    rdc("full high", sadc_pkg::OFF_RESH, 8'hFF);
    rdc("full low", sadc_pkg::OFF_RESL, 8'hC0);
    rdc("flag cleared", sadc_pkg::OFF_SCR, 8'h1D);
    wr(sadc_pkg::OFF_CLK, 8'h10);
    conv(8'h1E);
    rdc("zero high", sadc_pkg::OFF_RESH, 8'h00);
    rdc("zero low", sadc_pkg::OFF_RESL, 8'h00);
    vin = 10'h2B6;
    for (int f = 0; f < 4; f++) begin
      wr(sadc_pkg::OFF_CLK, {3'h3, 1'b0, f[1:0], 2'h0});
      conv(8'h05);
      if (f != 3) rdc("format high", sadc_pkg::OFF_RESH, fh[f]);
      rdc("format low", sadc_pkg::OFF_RESL, fl[f]);
    end
    // truncated: a high read does not hold back the next result
    bus(1'b0, sadc_pkg::OFF_RESH, 8'h00);
    vin = 10'h155;
    conv(8'h05);
    rdc("trunc no lock", sadc_pkg::OFF_RESL, 8'h55);
    wr(sadc_pkg::OFF_CLK, 8'h60);
    conv(8'h05);
    rdc("lock high", sadc_pkg::OFF_RESH, 8'h55);
    vin = 10'h2B6;
    wr(sadc_pkg::OFF_SCR, 8'h05);
    repeat (200) @(posedge clk_sys);
    rdc("locked low", sadc_pkg::OFF_RESL, 8'h40);
    rdc("lost result", sadc_pkg::OFF_RESH, 8'h55);
    bus(1'b0, sadc_pkg::OFF_RESL, 8'h00);
    // interrupt mode
    wr(sadc_pkg::OFF_SCR, 8'h5D);
    wait_irq();
    rdc("flag with irq", sadc_pkg::OFF_SCR, 8'h5D);
    rdc("irq result", sadc_pkg::OFF_RESH, 8'hFF);
    repeat (2) @(posedge clk_sys);
    chk_bit("irq after read", 1'b0, irq);
    bus(1'b0, sadc_pkg::OFF_RESL, 8'h00);
    // single mode: a control write clears a pending interrupt
    wr(sadc_pkg::OFF_SCR, 8'h5D);
    wait_irq();
    wr(sadc_pkg::OFF_SCR, 8'h5D);
    repeat (2) @(posedge clk_sys);
    chk_bit("irq after write", 1'b0, irq);
    // continuous mode
    vin = 10'h0F0;
    wr(sadc_pkg::OFF_SCR, 8'h25);
    repeat (150) @(posedge clk_sys);
    bus(1'b0, sadc_pkg::OFF_RESH, 8'h00);
    bus(1'b0, sadc_pkg::OFF_RESL, 8'h00);
    wait_done(1'b0);
    rdc("cont high", sadc_pkg::OFF_RESH, 8'h3C);
    rdc("cont low", sadc_pkg::OFF_RESL, 8'h00);
    vin = 10'h3C7;
    repeat (300) @(posedge clk_sys);
    rdc("overwrite high", sadc_pkg::OFF_RESH, 8'hF1);
    rdc("overwrite low", sadc_pkg::OFF_RESL, 8'hC0);
    conv(8'h05);
    bus(1'b0, sadc_pkg::OFF_RESH, 8'h00);
    bus(1'b0, sadc_pkg::OFF_RESL, 8'h00);
    repeat (300) @(posedge clk_sys);
    rdc("single idle", sadc_pkg::OFF_SCR, 8'h05);
    // pin override for each of the 24 pin channels
    port_dir <= 24'hFFFFFF;
    port_data <= 24'hA5A5A5;
    pin_in <= 24'hFFFFFF;
    repeat (6) @(posedge clk_sys);
    for (c = 5'h00; c < sadc_pkg::CH_PINS; c++) begin
      wr(sadc_pkg::OFF_SCR, {3'h0, c});
      repeat (4) @(posedge clk_sys);
      chk_pins("pin oe", ~(24'h1 << c), pin_oe);
      chk_pins("port read", ~(24'h1 << c), port_rd_data);
      chk_pins("pin out", 24'hA5A5A5, pin_out);
      chk_reg("mux", {27'h0, c}, {27'h0, amux_sel});
    end
    // stop aborts, release resumes
    wr(sadc_pkg::OFF_SCR, 8'h1D);
    repeat (40) @(posedge clk_sys);
    cpu_stop <= 1'b1;
    repeat (300) @(posedge clk_sys);
    rdc("stopped", sadc_pkg::OFF_SCR, 8'h1D);
    cpu_stop <= 1'b0;
    t0 = cyc;
    wait_done(1'b1);
    rdc("resumed high", sadc_pkg::OFF_RESH, 8'hFF);
    rdc("resumed low", sadc_pkg::OFF_RESL, 8'hC0);
    chk_bit("power on", 1'b1, adc_power_on);
    wr(sadc_pkg::OFF_SCR, 8'h1F);
    repeat (2) @(posedge clk_sys);
    chk_bit("power off", 1'b0, adc_power_on);
    repeat (300) @(posedge clk_sys);
    rdc("off idle", sadc_pkg::OFF_SCR, 8'h1F);
    wrap_up();
  end
endmodule
